// *** wer_route_top.sv ***
// wer_route_top: wake event routing enables with apb register access
// assumes: apb master, wake pins asynchronous, soft_reset synchronous to pclk
// How it works
// - bit n of the high-group management route register serves wake input n, bit 4 also the ring source.
// - a detected high-group event with its management route bit set drives smi_n low, whatever its wake enable.
// - low-group interrupt route bits are 6 software, 4 infrared, 3 mouse, 2 keyboard, 1 ring two, 0 ring one.
// - a detected low-group event with its route bit set raises irq, whatever its wake enable.
// - bit n of the high-group interrupt route register serves wake input n, bit 4 also ring, and raises irq.
// - the three route registers clear to zero on reset or soft reset.
// - gate bits are 4 infrared, 3 mouse, 2 keyboard, 1 ring two, 0 ring one, bits 7 to 5 reserved.
// - with main power present a raw low-group source reaches its detector only when its gate bit is one.
// - the gate register loads 1F on reset or soft reset.
// - the four registers sit at indices 14 to 17 of bank two and are read/write.
// - bank two registers answer only while the configuration bank field holds 10.
// - detected events enabled in the wake enable registers drive pwr_wake_req_n low.
`timescale 1ns/1ns
`default_nettype none

module wer_route_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wer_pkg::ADDR_W-1:0] paddr,
  input wire logic [wer_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [wer_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // wake pins
  input wire logic main_power_present,
  input wire logic [wer_pkg::LO_SRC_W-1:0] low_raw_src,
  input wire logic [wer_pkg::HI_SRC_W-1:0] general_wake_input,
  input wire logic ring_src,
  // event outputs
  output logic [wer_pkg::LO_SRC_W-1:0] low_src_gated,
  output logic system_management_interrupt_n,
  output logic irq,
  output logic power_wake_request_n
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic hit(input logic [wer_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
    return (a[wer_pkg::ADDR_W-1:10] == '0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  logic [wer_pkg::SYNC_W-1:0] sync_in, sync_s;
  logic main_s;
  logic [wer_pkg::LO_SRC_W-1:0] raw_lo_s;
  logic [wer_pkg::HI_SRC_W-1:0] raw_hi_s;
  logic [7:0] cfg_q, cfg_d, en_lo_q, en_lo_d, en_hi_q, en_hi_d;
  logic [7:0] mgmt_q, mgmt_d, irq_lo_q, irq_lo_d, irq_hi_q, irq_hi_d, gate_q, gate_d;
  logic [7:0] st_lo_q, st_lo_d, st_hi_q, st_hi_d, set_lo, set_hi, clr_lo, clr_hi;
  logic [wer_pkg::LO_SRC_W-1:0] gated_q, gated_d, prev_lo_q;
  logic [wer_pkg::HI_SRC_W-1:0] prev_hi_q;
  logic smi_n_q, smi_n_d, irq_q, irq_d, pwr_n_q, pwr_n_d;
  logic [wer_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic err_q, err_d;
  logic wr, bank_ok;
  logic [7:0] wdat, rd_val;
  logic rd_hit;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_comb begin
    sync_in = {main_power_present, general_wake_input, low_raw_src};
    sync_in[wer_pkg::SYNC_HI_LSB + wer_pkg::RING_SHARED_BIT] =
      general_wake_input[wer_pkg::RING_SHARED_BIT] | ring_src;
  end

  wer_sync #(.WIDTH(wer_pkg::SYNC_W)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sync_in),
    .sync_out(sync_s)
  );

  assign main_s = sync_s[wer_pkg::SYNC_MAINPWR_BIT];
  assign raw_lo_s = sync_s[wer_pkg::SYNC_LO_LSB +: wer_pkg::LO_SRC_W];
  assign raw_hi_s = sync_s[wer_pkg::SYNC_HI_LSB +: wer_pkg::HI_SRC_W];

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr = psel && penable && pwrite && pstrb[0];
  assign wdat = pwdata[7:0];
  assign bank_ok = cfg_q[wer_pkg::CFG_BANK_LSB +: 2] == wer_pkg::BANK_EVENT_ROUTING;

  always_comb begin
    cfg_d = cfg_q;
    en_lo_d = en_lo_q;
    en_hi_d = en_hi_q;
    mgmt_d = mgmt_q;
    irq_lo_d = irq_lo_q;
    irq_hi_d = irq_hi_q;
    gate_d = gate_q;
    if (soft_reset) begin
      cfg_d = wer_pkg::CFG_RST;
      en_lo_d = wer_pkg::EN_RST;
      en_hi_d = wer_pkg::EN_RST;
      mgmt_d = wer_pkg::ROUTE_RST;
      irq_lo_d = wer_pkg::ROUTE_RST;
      irq_hi_d = wer_pkg::ROUTE_RST;
      gate_d = wer_pkg::GATE_RST;
    end else if (wr) begin
      if (hit(paddr, wer_pkg::IDX_WAKE_CFG)) begin
        cfg_d = wdat & wer_pkg::CFG_MASK;
      end
      if (hit(paddr, wer_pkg::IDX_LO_WAKE_EN)) begin
        en_lo_d = wdat;
      end
      if (hit(paddr, wer_pkg::IDX_HI_WAKE_EN)) begin
        en_hi_d = wdat;
      end
      if (bank_ok && hit(paddr, wer_pkg::IDX_HI_MGMT_ROUTE)) begin
        mgmt_d = wdat;
      end
      if (bank_ok && hit(paddr, wer_pkg::IDX_LO_IRQ_ROUTE)) begin
        irq_lo_d = wdat & wer_pkg::LO_IRQ_MASK;
      end
      if (bank_ok && hit(paddr, wer_pkg::IDX_HI_IRQ_ROUTE)) begin
        irq_hi_d = wdat;
      end
      if (bank_ok && hit(paddr, wer_pkg::IDX_LO_MAINPWR_GATE)) begin
        gate_d = wdat & wer_pkg::GATE_MASK;
      end
    end
  end

  // ----------------------------------------
  // gating, event detection and sticky status
  // ----------------------------------------
  always_comb begin
    gated_d = raw_lo_s & (gate_q[wer_pkg::LO_SRC_W-1:0] | {wer_pkg::LO_SRC_W{~main_s}});
    set_lo = {3'h0, gated_q & ~prev_lo_q};
    set_hi = raw_hi_s & ~prev_hi_q;
    if (wr && hit(paddr, wer_pkg::IDX_SW_EVENT)) begin
      set_lo[wer_pkg::SW_EVENT_BIT] = wdat[wer_pkg::SW_EVENT_BIT];
    end
    clr_lo = (wr && hit(paddr, wer_pkg::IDX_LO_CLEAR)) ? wdat : 8'h00;
    clr_hi = (wr && hit(paddr, wer_pkg::IDX_HI_CLEAR)) ? wdat : 8'h00;
    // a new event wins over a clear in the same cycle
    st_lo_d = ((st_lo_q & ~clr_lo) | set_lo) & wer_pkg::LO_STATUS_MASK;
    st_hi_d = (st_hi_q & ~clr_hi) | set_hi;
    if (soft_reset) begin
      st_lo_d = 8'h00;
      st_hi_d = 8'h00;
    end
  end

  // ----------------------------------------
  // output combining
  // ----------------------------------------
  always_comb begin
    smi_n_d = ~|(st_hi_q & mgmt_q);
    irq_d = |(st_lo_q & irq_lo_q) | |(st_hi_q & irq_hi_q);
    pwr_n_d = ~(|(st_lo_q & en_lo_q) | |(st_hi_q & en_hi_q));
  end

  // ----------------------------------------
  // read path, one wait-free access phase
  // ----------------------------------------
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (hit(paddr, wer_pkg::IDX_WAKE_CFG)) begin
      rd_val = cfg_q;
    end else if (hit(paddr, wer_pkg::IDX_LO_WAKE_EN)) begin
      rd_val = en_lo_q;
    end else if (hit(paddr, wer_pkg::IDX_HI_WAKE_EN)) begin
      rd_val = en_hi_q;
    end else if (hit(paddr, wer_pkg::IDX_HI_MGMT_ROUTE)) begin
      rd_val = bank_ok ? mgmt_q : 8'h00;
    end else if (hit(paddr, wer_pkg::IDX_LO_IRQ_ROUTE)) begin
      rd_val = bank_ok ? irq_lo_q : 8'h00;
    end else if (hit(paddr, wer_pkg::IDX_HI_IRQ_ROUTE)) begin
      rd_val = bank_ok ? irq_hi_q : 8'h00;
    end else if (hit(paddr, wer_pkg::IDX_LO_MAINPWR_GATE)) begin
      rd_val = bank_ok ? gate_q : 8'h00;
    end else if (hit(paddr, wer_pkg::IDX_LO_STATUS)) begin
      rd_val = st_lo_q;
    end else if (hit(paddr, wer_pkg::IDX_HI_STATUS)) begin
      rd_val = st_hi_q;
    end else if (hit(paddr, wer_pkg::IDX_LO_CLEAR) || hit(paddr, wer_pkg::IDX_HI_CLEAR) ||
                 hit(paddr, wer_pkg::IDX_SW_EVENT)) begin
      rd_val = 8'h00;
    end else begin
      rd_hit = 1'b0;
    end
    prdata_d = prdata_q;
    err_d = err_q;
    if (psel && !penable) begin
      prdata_d = {24'h000000, rd_val};
      err_d = ~rd_hit;
    end
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= wer_pkg::CFG_RST;
      en_lo_q <= wer_pkg::EN_RST;
      en_hi_q <= wer_pkg::EN_RST;
      mgmt_q <= wer_pkg::ROUTE_RST;
      irq_lo_q <= wer_pkg::ROUTE_RST;
      irq_hi_q <= wer_pkg::ROUTE_RST;
      gate_q <= wer_pkg::GATE_RST;
      st_lo_q <= 8'h00;
      st_hi_q <= 8'h00;
      gated_q <= '0;
      prev_lo_q <= '0;
      prev_hi_q <= '0;
      smi_n_q <= 1'b1;
      irq_q <= 1'b0;
      pwr_n_q <= 1'b1;
      prdata_q <= '0;
      err_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      en_lo_q <= en_lo_d;
      en_hi_q <= en_hi_d;
      mgmt_q <= mgmt_d;
      irq_lo_q <= irq_lo_d;
      irq_hi_q <= irq_hi_d;
      gate_q <= gate_d;
      st_lo_q <= st_lo_d;
      st_hi_q <= st_hi_d;
      gated_q <= gated_d;
      prev_lo_q <= gated_q;
      prev_hi_q <= raw_hi_s;
      smi_n_q <= smi_n_d;
      irq_q <= irq_d;
      pwr_n_q <= pwr_n_d;
      prdata_q <= prdata_d;
      err_q <= err_d;
    end
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && err_q;
  assign prdata = prdata_q;
  assign low_src_gated = gated_q;
  assign system_management_interrupt_n = smi_n_q;
  assign irq = irq_q;
  assign power_wake_request_n = pwr_n_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  smi_route_a: assert property (((st_hi_q & mgmt_q) != 0) && (en_hi_q == 8'h00)
    |=> !system_management_interrupt_n)
    else $error("management interrupt not raised for routed event");
  irq_low_a: assert property (((st_lo_q & irq_lo_q) != 0) |=> irq)
    else $error("irq not raised for routed low event");
  irq_high_a: assert property (((st_hi_q & irq_hi_q) != 0) && (en_hi_q == 8'h00) |=> irq)
    else $error("irq not raised for routed high event");
  route_reset_a: assert property (soft_reset |=> (mgmt_q == 8'h00) && (irq_lo_q == 8'h00)
    && (irq_hi_q == 8'h00))
    else $error("route registers not cleared by soft reset");
  gate_reset_a: assert property (soft_reset |=> gate_q == wer_pkg::GATE_RST)
    else $error("gate register not reloaded by soft reset");
  gate_block_a: assert property (main_s |=> ({3'h0, gated_q} & ~$past(gate_q)) == 8'h00)
    else $error("gated source differs from gate setting");
  route_write_a: assert property (wr && bank_ok && !soft_reset && hit(paddr, wer_pkg::IDX_LO_IRQ_ROUTE)
    |=> irq_lo_q == ($past(wdat) & wer_pkg::LO_IRQ_MASK))
    else $error("low irq route write lost");
  bank_lock_a: assert property (wr && !bank_ok && !soft_reset && hit(paddr, wer_pkg::IDX_HI_MGMT_ROUTE)
    |=> $stable(mgmt_q))
    else $error("bank two register written outside bank two");
  wake_req_a: assert property (((st_lo_q & en_lo_q) != 0) |=> !power_wake_request_n)
    else $error("wake request not raised");
  reserved_zero_a: assert property (((irq_lo_q & ~wer_pkg::LO_IRQ_MASK) == 8'h00)
    && ((gate_q & ~wer_pkg::GATE_MASK) == 8'h00))
    else $error("reserved bit set");
  irq_quiet_a: assert property (((st_lo_q & irq_lo_q) == 0) && ((st_hi_q & irq_hi_q) == 0)
    |=> !irq)
    else $error("irq raised with no routed event");

  smi_seen_c: cover property (!system_management_interrupt_n ##1 system_management_interrupt_n);
  irq_seen_c: cover property ($rose(irq));
  wake_seen_c: cover property ($fell(power_wake_request_n));
  gate_held_c: cover property (main_s && (raw_lo_s != 0) && (gate_q[4:0] == 5'h00));

endmodule

`default_nettype wire

// *** wer_pkg.sv ***
// wer_pkg: constants shared by the wake event routing block
// assumes: apb byte addressing, register byte address = 4 * register index
`default_nettype none

package wer_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int LO_SRC_W = 5;
  localparam int HI_SRC_W = 8;
  localparam int SYNC_W = 14;

  // ----------------------------------------
  // register indices
  // ----------------------------------------
  localparam logic [7:0] IDX_LO_WAKE_EN = 8'h02;
  localparam logic [7:0] IDX_HI_WAKE_EN = 8'h03;
  localparam logic [7:0] IDX_WAKE_CFG = 8'h04;
  localparam logic [7:0] IDX_HI_MGMT_ROUTE = 8'h14;
  localparam logic [7:0] IDX_LO_IRQ_ROUTE = 8'h15;
  localparam logic [7:0] IDX_HI_IRQ_ROUTE = 8'h16;
  localparam logic [7:0] IDX_LO_MAINPWR_GATE = 8'h17;
  localparam logic [7:0] IDX_LO_STATUS = 8'h20;
  localparam logic [7:0] IDX_HI_STATUS = 8'h21;
  localparam logic [7:0] IDX_LO_CLEAR = 8'h22;
  localparam logic [7:0] IDX_HI_CLEAR = 8'h23;
  localparam logic [7:0] IDX_SW_EVENT = 8'h24;

  // ----------------------------------------
  // reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] GATE_RST = 8'h1F;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] LO_IRQ_MASK = 8'h5F;
  localparam logic [7:0] GATE_MASK = 8'h1F;
  localparam logic [7:0] CFG_MASK = 8'h0F;
  localparam logic [7:0] LO_STATUS_MASK = 8'h5F;
  localparam logic [7:0] FULL_MASK = 8'hFF;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  localparam int CFG_BANK_LSB = 0;
  localparam logic [1:0] BANK_EVENT_ROUTING = 2'b10;
  localparam int SW_EVENT_BIT = 6;
  localparam int RING_SHARED_BIT = 4;
  localparam int SYNC_LO_LSB = 0;
  localparam int SYNC_HI_LSB = 5;
  localparam int SYNC_MAINPWR_BIT = 13;

endpackage

`default_nettype wire

// *** wer_sync.sv ***
// wer_sync: three-stage synchroniser with agreement filter
// assumes: inputs are asynchronous to pclk
`timescale 1ns/1ns
`default_nettype none

module wer_sync #(
  parameter int WIDTH = 14
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  // ----------------------------------------
  // accept a change once stages two and three agree
  // ----------------------------------------
  always_comb begin
    out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

`default_nettype wire

// *** wer_host_model.sv ***
// wer_host_model: host chipset side that listens to the event outputs
// assumes: outputs of the routing block are registered to pclk
`timescale 1ns/1ns
`default_nettype none

module wer_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // event outputs seen by the host
  input wire logic irq,
  input wire logic system_management_interrupt_n,
  // what the host has taken
  output var int irq_cnt,
  output var int smi_cnt
);
  logic irq_q;
  logic smi_n_q;

  // count each new request, a level held active (irq high, smi_n low) is one request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      smi_n_q <= 1'b1;
      irq_cnt <= 0;
      smi_cnt <= 0;
    end else begin
      irq_q <= irq;
      smi_n_q <= system_management_interrupt_n;
      if (irq && !irq_q) irq_cnt <= irq_cnt + 1;
      if (!system_management_interrupt_n && smi_n_q) smi_cnt <= smi_cnt + 1;
    end
  end
endmodule

`default_nettype wire

// *** test_wake_event_routing_enables.sv ***
// test_wake_event_routing_enables: self-checking bench for wer_route_top
// assumes: apb master in this bench, host model listens to the outputs
`timescale 1ns/1ns
`default_nettype none

module test_wake_event_routing_enables;
  logic pclk = 0, presetn = 0, soft_reset = 0, psel = 0, penable = 0, pwrite = 0, main_pwr = 0, ring = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, smi_n, irq, pwr_n, er;
  logic [4:0] lo_src = 0, lo_gated;
  logic [7:0] gpi = 0;
  int miscompares = 0, samples_checked = 0, stl = 0, sth = 0, irq_cnt, smi_cnt;
  int rg[int];

  always #5 pclk = ~pclk;

  wer_route_top i_dut (.pclk(pclk), .presetn(presetn), .soft_reset(soft_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_power_present(main_pwr), .low_raw_src(lo_src),
    .general_wake_input(gpi), .ring_src(ring), .low_src_gated(lo_gated),
    .system_management_interrupt_n(smi_n), .irq(irq), .power_wake_request_n(pwr_n));

  wer_host_model i_host (.pclk(pclk), .presetn(presetn), .irq(irq), .system_management_interrupt_n(smi_n),
    .irq_cnt(irq_cnt), .smi_cnt(smi_cnt));

  // ----------------------------------------
  // reference model and checks
  // ----------------------------------------
  function automatic int msk(int i);
    return i == 8'h15 ? 8'h5F : i == 8'h17 ? 8'h1F : i == 4 ? 8'h0F : 8'hFF;
  endfunction

  function automatic bit bank_ok(int i);
    return i < 8'h14 || i > 8'h17 || (rg[4] & 3) == 2;
  endfunction

  task automatic results();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input int i, input int d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'(i * 4);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      miscompares++;
      results();
    end
    if (w && bank_ok(i) && rg.exists(i)) rg[i] = d & msk(i);
    if (w && i == 8'h22) stl &= ~d;
    if (w && i == 8'h23) sth &= ~d;
    if (w && i == 8'h24) stl |= d & 8'h40;
  endtask

  task automatic rdc(input int i);
    apb(1'b0, i, 0);
    chk(rd, bank_ok(i) ? rg[i] : 0);
  endtask

  // wait for the outputs to settle on the model's levels, then compare all three
  task automatic chkout();
    int n;
    logic es, ei, ep;
    es = (sth & rg[20]) == 0;
    ei = ((stl & rg[21]) | (sth & rg[22])) != 0;
    ep = ((stl & rg[2]) | (sth & rg[3])) == 0;
    for (n = 0; n < 30 && {smi_n, irq, pwr_n} !== {es, ei, ep}; n++) @(posedge pclk);
    chk(smi_n, es);
    chk(irq, ei);
    chk(pwr_n, ep);
    if (n == 30) results();
  endtask

  task automatic defaults();
    rg.delete();
    rg[2] = 0;
    rg[3] = 0;
    rg[4] = 0;
    rg[20] = 0;
    rg[21] = 0;
    rg[22] = 0;
    rg[23] = 31;
    stl = 0;
    sth = 0;
    apb(1'b1, 4, 2);
    foreach (rg[i]) if (i >= 20) rdc(i);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int n;
    n = $urandom(32'hbd6a);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    main_pwr <= 1'b1;
    defaults();
    foreach (rg[i]) if (i >= 20) begin
      apb(1'b1, i, $urandom);
      rdc(i);
      apb(1'b1, i, i == 23 ? 31 : 0);
    end
    apb(1'b1, 4, 1);
    rdc(20);
    apb(1'b1, 20, 255);
    apb(1'b1, 4, 2);
    rdc(20);
    apb(1'b0, 8'h30, 0);
    chk(er, 1);
    n = $urandom % 8;
    apb(1'b1, 20, 1 << n);
    gpi[n] <= 1'b1;
    sth |= 1 << n;
    chkout();
    apb(1'b0, 8'h21, 0);
    chk(rd, sth);
    gpi <= 8'h00;
    apb(1'b1, 8'h23, 255);
    chkout();
    apb(1'b1, 20, 0);
    apb(1'b1, 22, 16);
    ring <= 1'b1;
    sth |= 16;
    chkout();
    ring <= 1'b0;
    apb(1'b1, 8'h23, 255);
    apb(1'b1, 21, 64);
    apb(1'b1, 8'h24, 64);
    chkout();
    apb(1'b1, 8'h22, 255);
    chkout();
    apb(1'b1, 23, 30);
    apb(1'b1, 21, 1);
    lo_src <= 5'h01;
    repeat (10) @(posedge pclk);
    chk(lo_gated, 0);
    chkout();
    lo_src <= 5'h00;
    repeat (8) @(posedge pclk);
    apb(1'b1, 23, 31);
    lo_src <= 5'h01;
    stl |= 1;
    chkout();
    chk(lo_gated, 1);
    lo_src <= 5'h00;
    apb(1'b1, 8'h22, 255);
    apb(1'b1, 21, 0);
    apb(1'b1, 3, 128);
    gpi[7] <= 1'b1;
    sth |= 128;
    chkout();
    gpi <= 8'h00;
    chk(irq_cnt, 3);
    chk(smi_cnt, 1);
    soft_reset <= 1'b1;
    @(posedge pclk);
    soft_reset <= 1'b0;
    defaults();
    chkout();
    results();
  end
endmodule

`default_nettype wire
